// [core/brg_guard_ctrl.sv]
// inter-burst reconfiguration guard for upstream transmit parameters
//
// Behaviour
// - with no listed parameter change, bursts follow back to back untouched.
// - rate, offset-frequency or ranging changes need 96 symbols of gap.
// - modulation changes also need 96 symbols of gap.
// - listed parameters change only after drain, before next burst.
// - modulation changes only after drain, equalizer delay ignored.
// - channel frequency change needs 96 symbols plus 100 ms.
// - power change of 1 dB or less needs 96 symbols plus 5 us.
// - power change above 1 dB needs 96 symbols plus 10 us.
// - power spans 8 dBmV to 55 (16QAM) or 58 (QPSK).
// - power steps round to nearest whole dB.
// - midway power steps round to the smaller step.
// - ranging offset is unsigned, in frame tick sixty-fourths.
// - negative ranging adjustment decreases the stored offset.
`timescale 1ns/1ps
`default_nettype none
module brg_guard_ctrl
    import brg_pkg::*;
#(
    parameter int unsigned RETUNE_CYC = RETUNE_CYC_DFLT,
    parameter int          STEP_W     = 8
) (
    // clock and reset
    input  wire logic               clock_i,
    input  wire logic               rst_n_i,
    // timing from the burst engine
    input  wire logic               burst_end_i,
    input  wire logic [31:0]        grant_cyc_i,
    input  wire logic [15:0]        sym_cyc_i,
    // update request
    input  wire logic               upd_valid_i,
    input  wire logic [CHG_W-1:0]   upd_mask_i,
    input  wire logic [STEP_W-1:0]  upd_pwr_step_i,
    input  wire logic               upd_mod_i,
    input  wire logic [2:0]         upd_rate_i,
    input  wire logic [15:0]        upd_off_i,
    input  wire logic [31:0]        upd_freq_i,
    input  wire logic [15:0]        upd_rng_adj_i,
    output var  logic               upd_ready_o,
    // live transmit parameters
    output var  logic [6:0]         tx_power_o,
    output var  logic               modulation_o,
    output var  logic [2:0]         sym_rate_o,
    output var  logic [15:0]        offset_freq_o,
    output var  logic [31:0]        chan_freq_o,
    output var  logic [15:0]        rng_offset_o,
    // status
    output var  logic               pending_o,
    output var  logic               apply_o,
    output var  logic               settle_busy_o,
    output var  logic               gap_short_o
);
    initial begin
        if (RETUNE_CYC < 1 || STEP_W < 4 || STEP_W > 16) begin
            $error("brg_guard_ctrl: bad parameters");
        end
    end

    brg_pwr_if #(.IN_W(STEP_W)) pwr_c ();
    brg_pwr_quant #(.FRAC_BITS(2), .IN_W(STEP_W)) u_quant (.pwr(pwr_c));
    assign pwr_c.step_raw = upd_pwr_step_i;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    brg_state_t                state_reg,  state_next;
    logic [31:0]               cnt_reg,    cnt_next;
    logic [31:0]               settle_reg, settle_next;
    logic [CHG_W-1:0]          mask_reg,   mask_next;
    logic signed [STEP_W-1:0]  step_reg,   step_next;
    logic                      smod_reg,   smod_next;
    logic [2:0]                srate_reg,  srate_next;
    logic [15:0]               soff_reg,   soff_next;
    logic [31:0]               sfreq_reg,  sfreq_next;
    logic signed [15:0]        sadj_reg,   sadj_next;
    logic [6:0]                pwr_reg,    pwr_next;
    logic                      mod_reg,    mod_next;
    logic [2:0]                rate_reg,   rate_next;
    logic [15:0]               off_reg,    off_next;
    logic [31:0]               freq_reg,   freq_next;
    logic [15:0]               rng_reg,    rng_next;
    logic                      pend_reg,   pend_next;
    logic                      apply_reg,  apply_next;
    logic                      busy_reg,   busy_next;
    logic                      short_reg,  short_next;
    logic                      ready_reg,  ready_next;

    logic [31:0] gap_cyc;
    logic [31:0] need_cyc;
    logic [31:0] extra_cyc;
    logic        big_step;
    logic [6:0]  pwr_max;
    logic signed [8:0]  pwr_sum;
    logic signed [17:0] rng_sum;

    // ------------------------------------------------------------
    // gap requirement of the pending change
    // ------------------------------------------------------------
    always_comb begin
        gap_cyc   = 32'(GAP_SYM) * {16'h0000, sym_cyc_i};
        big_step  = (step_reg > STEP_W'(1)) || (step_reg < -STEP_W'(1));
        extra_cyc = 32'h0000_0000;
        if (mask_reg[CHG_PWR] && step_reg != '0) begin
            extra_cyc = big_step ? 32'(PWR_LARGE_CYC) : 32'(PWR_SMALL_CYC);
        end
        if (mask_reg[CHG_FREQ]) begin
            extra_cyc = 32'(RETUNE_CYC);
        end
        // base 96 symbol gap for any listed change
        need_cyc = (mask_reg != '0) ? gap_cyc + extra_cyc : 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // sequencing and parameter update
    // ------------------------------------------------------------
    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        settle_next = settle_reg;
        mask_next   = mask_reg;
        step_next   = step_reg;
        smod_next   = smod_reg;
        srate_next  = srate_reg;
        soff_next   = soff_reg;
        sfreq_next  = sfreq_reg;
        sadj_next   = sadj_reg;
        pwr_next    = pwr_reg;
        mod_next    = mod_reg;
        rate_next   = rate_reg;
        off_next    = off_reg;
        freq_next   = freq_reg;
        rng_next    = rng_reg;
        pend_next   = pend_reg;
        apply_next  = 1'b0;
        short_next  = 1'b0;
        busy_next   = busy_reg;
        pwr_sum     = '0;
        rng_sum     = '0;
        pwr_max     = PWR_MAX_QPSK;
        case (state_reg)
            BRG_IDLE: begin
                if (upd_valid_i && ready_reg) begin
                    mask_next  = upd_mask_i;
                    step_next  = pwr_c.step_db;
                    smod_next  = upd_mod_i;
                    srate_next = upd_rate_i;
                    soff_next  = upd_off_i;
                    sfreq_next = upd_freq_i;
                    sadj_next  = upd_rng_adj_i;
                    pend_next  = (upd_mask_i != '0);
                end else if (burst_end_i && pend_reg) begin
                    if (need_cyc > grant_cyc_i) begin
                        short_next = 1'b1;
                    end else begin
                        state_next  = BRG_DRAIN;
                        cnt_next    = 32'(DRAIN_SYM) * {16'h0000, sym_cyc_i};
                        settle_next = extra_cyc;
                    end
                end
            end
            BRG_DRAIN: begin
                // wait for the last burst to ramp out
                if (cnt_reg <= 32'h0000_0001) begin
                    state_next = BRG_APPLY;
                end else begin
                    cnt_next = cnt_reg - 32'h0000_0001;
                end
            end
            BRG_APPLY: begin
                apply_next = 1'b1;
                pend_next  = 1'b0;
                if (mask_reg[CHG_MOD]) begin
                    mod_next = smod_reg;
                end
                if (mask_reg[CHG_RATE]) begin
                    rate_next = srate_reg;
                end
                if (mask_reg[CHG_OFF]) begin
                    off_next = soff_reg;
                end
                if (mask_reg[CHG_FREQ]) begin
                    freq_next = sfreq_reg;
                end
                // clamp to the range of the new modulation
                pwr_max = (mod_next == BRG_MOD_QAM16) ? PWR_MAX_QAM16 : PWR_MAX_QPSK;
                pwr_sum = $signed({2'b00, pwr_reg}) + 9'(step_reg);
                if (mask_reg[CHG_PWR] || mask_reg[CHG_MOD]) begin
                    if (pwr_sum < $signed({2'b00, PWR_MIN_DBMV})) begin
                        pwr_next = PWR_MIN_DBMV;
                    end else if (pwr_sum > $signed({2'b00, pwr_max})) begin
                        pwr_next = pwr_max;
                    end else begin
                        pwr_next = pwr_sum[6:0];
                    end
                end
                // unsigned offset, negative adjust lowers it
                rng_sum = $signed({2'b00, rng_reg}) + 18'(sadj_reg);
                if (mask_reg[CHG_RNG]) begin
                    if (rng_sum < 18'sh00000) begin
                        rng_next = 16'h0000;
                    end else if (rng_sum > 18'sh0FFFF) begin
                        rng_next = 16'hFFFF;
                    end else begin
                        rng_next = rng_sum[15:0];
                    end
                end
                if (settle_reg != '0) begin
                    state_next = BRG_SETTLE;
                    busy_next  = 1'b1;
                end else begin
                    state_next = BRG_IDLE;
                end
            end
            BRG_SETTLE: begin
                // hold busy while the analog path settles
                if (settle_reg <= 32'h0000_0001) begin
                    state_next = BRG_IDLE;
                    busy_next  = 1'b0;
                end else begin
                    settle_next = settle_reg - 32'h0000_0001;
                end
            end
            default: begin
                state_next = BRG_IDLE;
                busy_next  = 1'b0;
            end
        endcase
        // nothing pending means nothing gates the burst
        ready_next = (state_next == BRG_IDLE) && !pend_next;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg  <= BRG_IDLE;
            cnt_reg    <= '0;
            settle_reg <= '0;
            mask_reg   <= '0;
            step_reg   <= '0;
            smod_reg   <= 1'b0;
            srate_reg  <= RATE_RST;
            soff_reg   <= '0;
            sfreq_reg  <= '0;
            sadj_reg   <= '0;
            pwr_reg    <= PWR_RST_DBMV;
            mod_reg    <= BRG_MOD_QPSK;
            rate_reg   <= RATE_RST;
            off_reg    <= '0;
            freq_reg   <= '0;
            rng_reg    <= RNG_RST;
            pend_reg   <= 1'b0;
            apply_reg  <= 1'b0;
            busy_reg   <= 1'b0;
            short_reg  <= 1'b0;
            ready_reg  <= 1'b0;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            settle_reg <= settle_next;
            mask_reg   <= mask_next;
            step_reg   <= step_next;
            smod_reg   <= smod_next;
            srate_reg  <= srate_next;
            soff_reg   <= soff_next;
            sfreq_reg  <= sfreq_next;
            sadj_reg   <= sadj_next;
            pwr_reg    <= pwr_next;
            mod_reg    <= mod_next;
            rate_reg   <= rate_next;
            off_reg    <= off_next;
            freq_reg   <= freq_next;
            rng_reg    <= rng_next;
            pend_reg   <= pend_next;
            apply_reg  <= apply_next;
            busy_reg   <= busy_next;
            short_reg  <= short_next;
            ready_reg  <= ready_next;
        end
    end

    assign upd_ready_o   = ready_reg;
    assign tx_power_o    = pwr_reg;
    assign modulation_o  = mod_reg;
    assign sym_rate_o    = rate_reg;
    assign offset_freq_o = off_reg;
    assign chan_freq_o   = freq_reg;
    assign rng_offset_o  = rng_reg;
    assign pending_o     = pend_reg;
    assign apply_o       = apply_reg;
    assign settle_busy_o = busy_reg;
    assign gap_short_o   = short_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_accept_gap;
        state_reg == BRG_IDLE && burst_end_i && pend_reg && !(upd_valid_i && ready_reg);
    endsequence

    a_short_defers : assert property (
        s_accept_gap and (need_cyc > grant_cyc_i) |=> gap_short_o && pending_o
            && state_reg == BRG_IDLE) else $error("short gap not deferred");

    a_gap_96sym : assert property (
        s_accept_gap ##1 state_reg == BRG_DRAIN |-> $past(grant_cyc_i) >= $past(gap_cyc))
        else $error("change accepted under 96 symbols");

    a_apply_drained : assert property (
        $rose(apply_o) |-> $past(state_reg, 2) == BRG_DRAIN) else $error("apply before drain");

    a_mod_in_gap : assert property (
        $changed(modulation_o) |-> apply_o) else $error("modulation changed outside gap");

    a_hold_params : assert property (
        !apply_o |-> $stable(tx_power_o) && $stable(chan_freq_o) && $stable(rng_offset_o)
            && $stable(sym_rate_o) && $stable(offset_freq_o)) else $error("parameter moved");

    a_power_range : assert property (
        tx_power_o >= PWR_MIN_DBMV && tx_power_o <= PWR_MAX_QPSK
            && (modulation_o == BRG_MOD_QPSK || tx_power_o <= PWR_MAX_QAM16))
        else $error("power out of range");

    a_rng_decrease : assert property (
        state_reg == BRG_APPLY && mask_reg[CHG_RNG] && sadj_reg < 0 && rng_reg != 16'h0000
            |=> rng_offset_o < $past(rng_reg)) else $error("offset not reduced");

    a_freq_settle : assert property (
        state_reg == BRG_APPLY && mask_reg[CHG_FREQ] |=> settle_busy_o [*8])
        else $error("retune window too short");

    a_pwr_small : assert property (
        s_accept_gap and (mask_reg == CHG_W'(1)) and !big_step and step_reg != '0
            and (need_cyc <= grant_cyc_i)
            |=> settle_reg == 32'(PWR_SMALL_CYC)) else $error("small power settle wrong");

    a_quant_half : assert property (
        upd_pwr_step_i == STEP_W'(2) |-> pwr_c.step_db == '0) else $error("half step not down");

    a_quant_near : assert property (
        upd_pwr_step_i == STEP_W'(3) |-> pwr_c.step_db == STEP_W'(1)) else $error("not nearest");

    a_quant_tie_neg : assert property (
        upd_pwr_step_i == STEP_W'(-2) |-> pwr_c.step_db == '0) else $error("neg half not down");

endmodule
`default_nettype wire

// [core/brg_pkg.sv]
// shared constants and types for the burst reconfiguration guard
package brg_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_MHZ     = 100;
    localparam int unsigned GAP_SYM          = 96;
    localparam int unsigned DRAIN_SYM        = 48;
    localparam int unsigned T_PWR_SMALL_NS   = 5000;
    localparam int unsigned T_PWR_LARGE_NS   = 10000;
    localparam int unsigned T_RETUNE_MS      = 100;
    // least times, rounded up to whole cycles
    localparam int unsigned PWR_SMALL_CYC    = (T_PWR_SMALL_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int unsigned PWR_LARGE_CYC    = (T_PWR_LARGE_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int unsigned RETUNE_CYC_DFLT  = T_RETUNE_MS * 1000 * CLK_FREQ_MHZ;

    // ------------------------------------------------------------
    // power range in dBmV and reset values
    // ------------------------------------------------------------
    localparam logic [6:0] PWR_MIN_DBMV      = 7'h08;
    localparam logic [6:0] PWR_MAX_QAM16     = 7'h37;
    localparam logic [6:0] PWR_MAX_QPSK      = 7'h3A;
    localparam logic [6:0] PWR_RST_DBMV      = 7'h08;
    localparam logic [15:0] RNG_RST          = 16'h0000;
    localparam logic [2:0] RATE_RST          = 3'h0;

    // ------------------------------------------------------------
    // change mask bit positions
    // ------------------------------------------------------------
    localparam int unsigned CHG_PWR          = 0;
    localparam int unsigned CHG_MOD          = 1;
    localparam int unsigned CHG_RATE         = 2;
    localparam int unsigned CHG_OFF          = 3;
    localparam int unsigned CHG_FREQ         = 4;
    localparam int unsigned CHG_RNG          = 5;
    localparam int unsigned CHG_W            = 6;

    typedef enum logic [0:0] {
        BRG_MOD_QPSK  = 1'b0,
        BRG_MOD_QAM16 = 1'b1
    } brg_mod_t;

    typedef enum logic [1:0] {
        BRG_IDLE   = 2'b00,
        BRG_DRAIN  = 2'b01,
        BRG_APPLY  = 2'b10,
        BRG_SETTLE = 2'b11
    } brg_state_t;

endpackage

// [core/brg_pwr_if.sv]
// power step carrier between the guard and its quantiser
`timescale 1ns/1ps
`default_nettype none
interface brg_pwr_if #(
    parameter int IN_W = 8
);
    logic signed [IN_W-1:0] step_raw;
    logic signed [IN_W-1:0] step_db;

    modport drv   (output step_raw, input step_db);
    modport quant (input step_raw, output step_db);
endinterface
`default_nettype wire

// [core/brg_pwr_quant.sv]
// rounds a fine power step to whole dB, ties toward the smaller step
`timescale 1ns/1ps
`default_nettype none
module brg_pwr_quant #(
    parameter int FRAC_BITS = 2,
    parameter int IN_W      = 8
) (
    // carrier
    brg_pwr_if.quant pwr
);
    initial begin
        if (FRAC_BITS < 1 || IN_W <= FRAC_BITS + 1) begin
            $error("brg_pwr_quant: bad widths");
        end
    end

    localparam logic [IN_W:0] HALF_M1 = (IN_W+1)'((1 << (FRAC_BITS - 1)) - 1);

    logic [IN_W:0] mag;
    logic [IN_W:0] rnd;

    // ------------------------------------------------------------
    // magnitude rounding
    // ------------------------------------------------------------
    always_comb begin
        mag = pwr.step_raw[IN_W-1] ? (IN_W+1)'(-$signed({pwr.step_raw[IN_W-1], pwr.step_raw}))
                                   : (IN_W+1)'({1'b0, pwr.step_raw});
        rnd = (mag + HALF_M1) >> FRAC_BITS;
        pwr.step_db = pwr.step_raw[IN_W-1] ? IN_W'(-$signed(rnd)) : IN_W'(rnd);
    end

endmodule
`default_nettype wire

// [verification/brg_guard_ctrl_bench.sv]
// self-checking bench for the burst reconfiguration guard
`timescale 1ns/1ps
`default_nettype none
module brg_guard_ctrl_bench
    import brg_pkg::*;
;
    localparam int SYM = 2;
    localparam int RET = 20;
    localparam int APPLY_AT = DRAIN_SYM * SYM + 1;
    localparam int LIMIT = 40000;

    // ----
    // signals
    // ----
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        burst_end, upd_valid, upd_mod, ready, mod_o, pending, apply, busy, gshort;
    logic [31:0] grant, upd_freq, freq_o;
    logic [5:0]  upd_mask;
    logic [7:0]  upd_step;
    logic [2:0]  upd_rate, rate_o;
    logic [15:0] upd_off, upd_adj, off_o, rng_o;
    logic [6:0]  pwr_o;
    logic [15:0] sym_cyc = 16'(SYM);
    int          failures = 0;
    int          comparisons = 0;
    int          cycles = 0;

    always #5 clock_i = ~clock_i;

    brg_headend_model i_brg_headend_model (
        .clock_i(clock_i), .sym_cyc_i(sym_cyc), .burst_end_o(burst_end), .grant_cyc_o(grant));

    brg_guard_ctrl #(.RETUNE_CYC(RET), .STEP_W(8)) i_brg_guard_ctrl (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .burst_end_i(burst_end), .grant_cyc_i(grant),
        .sym_cyc_i(sym_cyc), .upd_valid_i(upd_valid), .upd_mask_i(upd_mask),
        .upd_pwr_step_i(upd_step), .upd_mod_i(upd_mod), .upd_rate_i(upd_rate),
        .upd_off_i(upd_off), .upd_freq_i(upd_freq), .upd_rng_adj_i(upd_adj),
        .upd_ready_o(ready), .tx_power_o(pwr_o), .modulation_o(mod_o), .sym_rate_o(rate_o),
        .offset_freq_o(off_o), .chan_freq_o(freq_o), .rng_offset_o(rng_o),
        .pending_o(pending), .apply_o(apply), .settle_busy_o(busy), .gap_short_o(gshort));

    // ----
    // helpers
    // ----
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_n(input string what, input int exp, input int got);
        comparisons++;
        if (got != exp) begin
            failures++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        if (failures == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            $display("BAD cycle_limit expected below %0d seen %0d", LIMIT, cycles);
            wrap_up();
        end
    end

    task automatic offer(input logic [5:0] m, input logic [7:0] s);
        for (int i = 0; i < 3000 && ready !== 1'b1; i++) begin
            @(posedge clock_i);
            #1;
        end
        upd_mask = m;
        upd_step = s;
        upd_valid = 1'b1;
        @(posedge clock_i);
        #1;
        upd_valid = 1'b0;
        chk("pending", 32'(m != 6'h00), pending);
    endtask

    // one burst end; either refused as short or applied after drain
    task automatic gap(input int extra, input int neg, input bit sh, input int bexp);
        int n;
        int b;
        n = 0;
        i_brg_headend_model.issue(extra, neg, sh);
        while (n < 2000 && apply !== 1'b1 && gshort !== 1'b1) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        if (sh) begin
            chk_n("short_at", 0, n);
            chk("pending_kept", 1'b1, pending);
        end else begin
            chk_n("apply_at", APPLY_AT, n);
            b = (busy === 1'b1) ? 1 : 0;
            while (b < 3000 && ready !== 1'b1) begin
                @(posedge clock_i);
                #1;
                if (busy === 1'b1) b++;
            end
            chk_n("settle", bexp, b);
        end
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_small();
        offer(6'(1 << CHG_PWR), 8'h04);
        gap(PWR_SMALL_CYC, 0, 1'b1, 0);
        chk("power_held", 7'h08, pwr_o);
        gap(PWR_SMALL_CYC, 0, 1'b0, PWR_SMALL_CYC);
        chk("power", 7'h09, pwr_o);
    endtask

    task automatic t_round();
        logic [7:0] st[6] = '{8'h02, 8'h03, 8'hFE, 8'hFD, 8'h06, 8'hFA};
        logic [6:0] ex[6] = '{7'h09, 7'h0A, 7'h0A, 7'h09, 7'h0A, 7'h09};
        int bx[6] = '{0, PWR_SMALL_CYC, 0, PWR_SMALL_CYC, PWR_SMALL_CYC, PWR_SMALL_CYC};
        for (int i = 0; i < 6; i++) begin
            offer(6'(1 << CHG_PWR), st[i]);
            gap(PWR_SMALL_CYC, 0, 1'b0, bx[i]);
            chk("rounded", ex[i], pwr_o);
        end
    endtask

    task automatic t_large();
        offer(6'(1 << CHG_PWR), 8'h08);
        gap(PWR_LARGE_CYC, 0, 1'b1, 0);
        gap(PWR_LARGE_CYC, 0, 1'b0, PWR_LARGE_CYC);
        chk("power", 7'h0B, pwr_o);
        offer(6'(1 << CHG_PWR), 8'h7F);
        gap(PWR_LARGE_CYC, 0, 1'b0, PWR_LARGE_CYC);
        chk("power", 7'h2B, pwr_o);
        offer(6'(1 << CHG_PWR), 8'h7F);
        gap(PWR_LARGE_CYC, 0, 1'b0, PWR_LARGE_CYC);
        chk("qpsk_max", PWR_MAX_QPSK, pwr_o);
        upd_mod = 1'b1;
        offer(6'(1 << CHG_MOD), 8'h00);
        gap(0, 0, 1'b1, 0);
        gap(0, 0, 1'b0, 0);
        chk("mod", BRG_MOD_QAM16, mod_o);
        chk("qam_max", PWR_MAX_QAM16, pwr_o);
    endtask

    task automatic t_chan();
        upd_rate = 3'h5;
        upd_off = 16'h1234;
        offer(6'(1 << CHG_RATE) | 6'(1 << CHG_OFF), 8'h00);
        gap(0, 0, 1'b1, 0);
        gap(0, 0, 1'b0, 0);
        chk("rate", 3'h5, rate_o);
        chk("offset", 16'h1234, off_o);
        upd_freq = 32'h0ABC_DEF0;
        offer(6'(1 << CHG_FREQ), 8'h00);
        gap(RET, 0, 1'b1, 0);
        gap(RET, 0, 1'b0, RET);
        chk("freq", 32'h0ABC_DEF0, freq_o);
    endtask

    task automatic t_rng();
        logic [15:0] adj[3] = '{16'h0064, 16'hFFE2, 16'hFF38};
        logic [15:0] ex[3] = '{16'h0064, 16'h0046, 16'h0000};
        int neg[3] = '{0, 30, 200};
        for (int i = 0; i < 3; i++) begin
            upd_adj = adj[i];
            offer(6'(1 << CHG_RNG), 8'h00);
            gap(0, neg[i], 1'b0, 0);
            chk("ranging", ex[i], rng_o);
        end
    endtask

    task automatic t_none();
        int s;
        s = 0;
        offer(6'h00, 8'h00);
        i_brg_headend_model.issue(0, 0, 1'b0);
        for (int i = 0; i < 150; i++) begin
            @(posedge clock_i);
            #1;
            if (gshort === 1'b1) s++;
        end
        chk_n("no_short", 0, s);
        chk("power_same", PWR_MAX_QAM16, pwr_o);
    endtask

    initial begin
        {burst_end, upd_valid, upd_mod, upd_mask, upd_step} = '0;
        {upd_rate, upd_off, upd_freq, upd_adj} = '0;
        repeat (10) @(posedge clock_i);
        #1;
        chk("rst_power", PWR_RST_DBMV, pwr_o);
        chk("rst_rng", RNG_RST, rng_o);
        chk("rst_ready", 1'b0, ready);
        rst_n_i = 1'b1;
        repeat (2) @(posedge clock_i);
        #1;
        chk("ready", 1'b1, ready);
        t_small();
        t_round();
        t_large();
        t_chan();
        t_rng();
        t_none();
        wrap_up();
    end
endmodule
`default_nettype wire

// [verification/brg_headend_model.sv]
// headend grant scheduler model: burst ends and granted gaps
`timescale 1ns/1ps
`default_nettype none
module brg_headend_model
    import brg_pkg::*;
(
    // clock and config
    input  wire logic        clock_i,
    input  wire logic [15:0] sym_cyc_i,
    // grant side
    output var  logic        burst_end_o,
    output var  logic [31:0] grant_cyc_o
);
    initial begin
        burst_end_o = 1'b0;
        grant_cyc_o = 32'h0000_0000;
    end

    task automatic issue(input int extra, input int neg, input bit short1);
        logic [31:0] g;
        g = 32'(GAP_SYM * sym_cyc_i + extra + neg - (short1 ? 1 : 0));
        @(posedge clock_i);
        #1;
        burst_end_o = 1'b1;
        grant_cyc_o = g;
        @(posedge clock_i);
        #1;
        burst_end_o = 1'b0;
        // grant no longer valid: show garbage
        grant_cyc_o = ~g;
    endtask
endmodule
`default_nettype wire
